// ==== rtl/scx_xfer_ctl.sv ====
// Store coupler transfer sequencing: start, request hold and end timing
// ------------------------------------------------------------------
// Notes on behaviour
// - Buffer address alternates write side and read side each half period.
// - Write accept pulse sets force flop at phase one; it sets go-central.
// - Otherwise go-central is set by the controller accepting a request.
// - Same pulse resets request hold, blocking first controller request.
// - On writes, request hold sets once two words are buffered.
// - On reads, request hold sets at once; no request delay.
// - Completion needs zero count, plus final controller accept on writes.
// - Zero count sets start-end; end counter leaves preset, counts periods.
// - Enable-end-time comes 2100 ns (read) or 2500 ns (write) later.
// - End-time sets transfer clear at next phase; clears all but abort and the buffer address counters.
// - Abort flop clears only on new accept or master clear.
// - Master clear acts as transfer clear; end-time reset ends clear.
// - Clean end sends end-of-transfer and store end-of-transfer.
// - Read abort does not end; remaining words are zero-filled.
// - Abort or error sends error end-of-transfer; abort goes to coder.
// - Write abort sets end-time at once.
// - Processor exchange-terminate ends transfer with store end signal.
// - Zero count or error within 550 ns of accept ends at once.
// - Address bit 23 flag operation ends on controller accept.
// - Buffer addresses increment per word, the output one on writes only; wrap at 16, preset on accept.
// ------------------------------------------------------------------
`timescale 1ns/1ps
module scx_xfer_ctl (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic coupler_accept,
  input  wire logic write_op,
  input  wire logic ctrl_accept,
  input  wire logic ctrl_abort,
  input  wire logic error_flag,
  input  wire logic wc_zero,
  input  wire logic cpu_exchange_terminate,
  input  wire logic word_strobe,
  input  wire logic addr_bit23,
  input  wire logic master_clear,
  output logic      memory_side_request,
  output logic      bulk_store_request,
  output logic [3:0] buf_addr,
  output logic      buf_read_half,
  output logic      end_of_transfer,
  output logic      store_end_of_transfer,
  output logic      error_end_of_transfer,
  output logic      abort_to_code_gen,
  output logic      zero_fill,
  output logic      transfer_clear
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins settle through three stages; a change is taken once the
  // last two agree, so a runt glitch never reaches the control flops.
  logic [scx_pkg::NSYNC-1:0] s1, s2, s3, sq, sq_d;
  genvar g;
  for (g = 0; g < scx_pkg::NSYNC; g++) begin : g_sync
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        s1[g] <= 1'b0;
        s2[g] <= 1'b0;
        s3[g] <= 1'b0;
        sq[g] <= 1'b0;
      end else begin
        s1[g] <= g == scx_pkg::IN_ACCEPT ? coupler_accept
               : g == scx_pkg::IN_WRITE  ? write_op
               : g == scx_pkg::IN_CACC   ? ctrl_accept
               : g == scx_pkg::IN_ABORT  ? ctrl_abort
               : g == scx_pkg::IN_ERROR  ? error_flag
               : g == scx_pkg::IN_WCZ    ? wc_zero
               : g == scx_pkg::IN_EXCH   ? cpu_exchange_terminate
               : g == scx_pkg::IN_STROBE ? word_strobe
               : g == scx_pkg::IN_FLAG   ? addr_bit23
               : master_clear;
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g])
          sq[g] <= s3[g];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      sq_d <= '0;
    else
      sq_d <= sq;
  end

  wire [scx_pkg::NSYNC-1:0] rise = sq & ~sq_d;
  wire wr        = sq[scx_pkg::IN_WRITE];
  wire acc_rise  = rise[scx_pkg::IN_ACCEPT];
  wire cacc_rise = rise[scx_pkg::IN_CACC];
  wire strobe    = rise[scx_pkg::IN_STROBE];
  wire err       = sq[scx_pkg::IN_ERROR];
  wire wcz       = sq[scx_pkg::IN_WCZ];
  wire mclr      = sq[scx_pkg::IN_MCLR];

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  logic [4:0] phase;
  always_ff @(posedge clock) begin
    if (sys_rst || phase == scx_pkg::PH_LAST)
      phase <= 5'h00;
    else
      phase <= phase + 5'h01;
  end
  wire phase_one   = phase == 5'h00;
  wire phase_three = phase == scx_pkg::PH_THREE;
  wire phase_13    = phase_one || phase_three;
  wire read_half   = phase >= scx_pkg::PH_THREE;

  // ----------------------------------------------------------------
  // Accept pulse and one-shot
  // ----------------------------------------------------------------
  logic pulse_on, busy, flag_op, abort_ff, exch_ff;
  logic force_set, go_central, req_hold, req_q;
  logic start_end, end_time, end_time_d, acc_zero, flag_hit;
  logic [1:0] words;
  logic [7:0] win;
  logic enable_end;

  wire clr       = transfer_clear || mclr;
  wire pulse_end = pulse_on && phase_one;
  wire done      = wcz && (!wr || acc_zero);
  wire early     = win != 8'h00 && (wcz || err);
  wire set_end   = enable_end
                || (abort_ff && wr && busy)
                || exch_ff
                || (busy && early)
                || flag_hit;
  wire end_rise  = end_time && !end_time_d;

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      pulse_on <= 1'b0;
    else if (acc_rise)
      pulse_on <= 1'b1;
    else if (phase_one)
      pulse_on <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr) begin
      busy    <= 1'b0;
      flag_op <= 1'b0;
    end else if (acc_rise) begin
      busy    <= 1'b1;
      flag_op <= sq[scx_pkg::IN_FLAG];
    end
  end

  // Window after accept in which an early end is taken
  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      win <= 8'h00;
    else if (acc_rise)
      win <= scx_pkg::WIN_LAST;
    else if (win != 8'h00)
      win <= win - 8'h01;
  end

  // ----------------------------------------------------------------
  // Start control
  // ----------------------------------------------------------------
  // Flag operations need no memory, so the early start stays off.
  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      force_set <= 1'b0;
    else if (pulse_end && wr && !flag_op)
      force_set <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      go_central <= 1'b0;
    else if (force_set)
      go_central <= 1'b1;
    else if (busy && !flag_op && cacc_rise)
      go_central <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr || acc_rise)
      words <= 2'h0;
    else if (strobe && words != scx_pkg::WORDS_TO_REQ)
      words <= words + 2'h1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      req_hold <= 1'b0;
    else if (pulse_on && wr)
      req_hold <= 1'b0;
    else if (!wr && busy)
      req_hold <= 1'b1;
    else if (words == scx_pkg::WORDS_TO_REQ)
      req_hold <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      req_q <= 1'b0;
    else
      req_q <= busy && req_hold && !end_time;
  end

  // ----------------------------------------------------------------
  // End control
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || clr || acc_rise)
      acc_zero <= 1'b0;
    else if (wcz && cacc_rise)
      acc_zero <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      start_end <= 1'b0;
    else if (busy && done)
      start_end <= 1'b1;
  end

  scx_end_timer u_timer (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .run        (start_end),
    .tick       (phase_one),
    .write_op   (wr),
    .enable_end (enable_end)
  );

  // Abort survives transfer clear so the code generator still sees it
  always_ff @(posedge clock) begin
    if (sys_rst || mclr || acc_rise)
      abort_ff <= 1'b0;
    else if (busy && sq[scx_pkg::IN_ABORT])
      abort_ff <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      exch_ff <= 1'b0;
    else if (busy && rise[scx_pkg::IN_EXCH])
      exch_ff <= 1'b1;
  end

  // Accept is a one-cycle event; hold it until the next phase point
  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      flag_hit <= 1'b0;
    else if (flag_op && cacc_rise)
      flag_hit <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr)
      end_time <= 1'b0;
    else if (phase_13 && set_end)
      end_time <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      transfer_clear <= 1'b0;
    else if (mclr)
      transfer_clear <= 1'b0;
    else if (phase_13)
      transfer_clear <= end_time;
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      end_time_d <= 1'b0;
    else
      end_time_d <= end_time;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      end_of_transfer       <= 1'b0;
      store_end_of_transfer <= 1'b0;
      error_end_of_transfer <= 1'b0;
      abort_to_code_gen     <= 1'b0;
      zero_fill             <= 1'b0;
      memory_side_request   <= 1'b0;
      bulk_store_request    <= 1'b0;
    end else begin
      end_of_transfer       <= end_rise && !exch_ff && !abort_ff
                               && !err;
      store_end_of_transfer <= end_rise;
      error_end_of_transfer <= end_rise && (abort_ff || err);
      abort_to_code_gen     <= abort_ff;
      zero_fill             <= abort_ff && !wr && busy;
      memory_side_request   <= go_central;
      bulk_store_request    <= req_q;
    end
  end

  // ----------------------------------------------------------------
  // Buffer address counters
  // ----------------------------------------------------------------
  scx_buf_if bif ();
  assign bif.preset    = pulse_on;
  assign bif.inc_in    = strobe;
  assign bif.inc_out   = wr && busy && cacc_rise;
  assign bif.read_half = read_half;
  assign buf_addr      = bif.addr;
  assign buf_read_half = bif.addr_half;

  scx_buf_addr u_addr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .bus     (bif.cnt)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_write_pulse;
    pulse_on && wr && !flag_op && phase_one;
  endsequence

  force_go_a: assert property (s_write_pulse ##1 !clr |-> ##1 force_set
    ##1 go_central) else $error("Write start did not reach go-central");
  hold_block_a: assert property (
    wr && busy && words != 2'h2 && $past(pulse_on) |-> !req_hold)
    else $error("Controller request released too early");
  abort_keep_a: assert property (
    $fell(abort_ff) |-> $past(acc_rise) || $past(mclr))
    else $error("Abort flop cleared by other cause");
  end_phase_a: assert property (
    $rose(end_time) |-> $past(phase_13) && $past(set_end))
    else $error("End-time set off phase or without cause");
  read_abort_a: assert property (
    !wr && abort_ff && !enable_end && !exch_ff && !early && !flag_op
    |=> !$rose(end_time))
    else $error("Read abort ended the transfer");
  clear_a: assert property (
    transfer_clear |=> !force_set && !go_central && !start_end)
    else $error("Transfer clear left a control flop set");
  eot_a: assert property (
    $rose(store_end_of_transfer)
    |-> !(end_of_transfer && error_end_of_transfer))
    else $error("Both success and error end signalled");
  timer_a: assert property (
    $rose(start_end) && !wr && !clr ##0 (!clr)[*8] |-> !enable_end)
    else $error("End time enabled too soon");
  half_a: assert property (
    phase_one |=> (!bif.read_half)[*3])
    else $error("Address half wrong after phase one");
  read_req_a: assert property (
    !wr && busy && !clr && !pulse_on |=> req_hold || clr)
    else $error("Read request held back");
endmodule

// ==== rtl/scx_pkg.sv ====
// Constants shared by the store coupler transfer control block
package scx_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 4;
  localparam int PERIOD_NS  = 100;
  localparam int HALF_NS    = 50;
  localparam int WIN_NS     = 550;
  localparam int END_RD_NS  = 2100;
  localparam int END_WR_NS  = 2500;
  localparam int PH_CYC     = PERIOD_NS / CLK_NS;
  localparam int HALF_CYC   = HALF_NS / CLK_NS;
  localparam int WIN_CYC    = WIN_NS / CLK_NS;
  localparam int END_RD_PER = END_RD_NS / PERIOD_NS;
  localparam int END_WR_PER = END_WR_NS / PERIOD_NS;
  localparam logic [4:0] PH_LAST  = 5'(PH_CYC - 1);
  localparam logic [4:0] PH_THREE = 5'(HALF_CYC);
  localparam logic [7:0] WIN_LAST = 8'(WIN_CYC);
  // ----------------------------------------------------------------
  // End-time decode on counter bits 4, 8 and 16
  // ----------------------------------------------------------------
  localparam logic [4:0] END_RD_MASK = 5'h14;
  localparam logic [4:0] END_WR_MASK = 5'h18;
  // ----------------------------------------------------------------
  // Buffer and word counts
  // ----------------------------------------------------------------
  localparam int         BUF_WORDS    = 16;
  localparam int         BUF_AW       = 4;
  localparam logic [1:0] WORDS_TO_REQ = 2'h2;
  localparam logic [3:0] ADDR_RESET   = 4'h0;
  // ----------------------------------------------------------------
  // Synchronised input positions
  // ----------------------------------------------------------------
  localparam int NSYNC     = 10;
  localparam int IN_ACCEPT = 0;
  localparam int IN_WRITE  = 1;
  localparam int IN_CACC   = 2;
  localparam int IN_ABORT  = 3;
  localparam int IN_ERROR  = 4;
  localparam int IN_WCZ    = 5;
  localparam int IN_EXCH   = 6;
  localparam int IN_STROBE = 7;
  localparam int IN_FLAG   = 8;
  localparam int IN_MCLR   = 9;
endpackage

// ==== rtl/scx_buf_if.sv ====
// Buffer address control carried between transfer control and counters
`timescale 1ns/1ps
interface scx_buf_if;
  logic       preset;
  logic       inc_in;
  logic       inc_out;
  logic       read_half;
  logic [3:0] addr;
  logic       addr_half;
  modport ctl (output preset, inc_in, inc_out, read_half,
               input addr, addr_half);
  modport cnt (input preset, inc_in, inc_out, read_half,
               output addr, addr_half);
endinterface

// ==== rtl/scx_buf_addr.sv ====
// Buffer input and output address counters with half-period multiplexer
`timescale 1ns/1ps
module scx_buf_addr (
  input wire logic clock,
  input wire logic sys_rst,
  scx_buf_if.cnt   bus
);
  logic [3:0] in_addr;
  logic [3:0] out_addr;
  wire  [3:0] sel_addr = bus.read_half ? out_addr : in_addr;

  // ----------------------------------------------------------------
  // Counters wrap from 15 to 0 on their own 4-bit width
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || bus.preset) begin
      in_addr  <= scx_pkg::ADDR_RESET;
      out_addr <= scx_pkg::ADDR_RESET;
    end else begin
      if (bus.inc_in)
        in_addr <= in_addr + 4'h1;
      if (bus.inc_out)
        out_addr <= out_addr + 4'h1;
    end
  end

  // Write side in one half period, read side in the other
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus.addr      <= scx_pkg::ADDR_RESET;
      bus.addr_half <= 1'b0;
    end else begin
      bus.addr      <= sel_addr;
      bus.addr_half <= bus.read_half;
    end
  end
endmodule

// ==== rtl/scx_end_timer.sv ====
// End-time counter and decoder, stepped once per 100 ns period
`timescale 1ns/1ps
module scx_end_timer (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic run,
  input  wire logic tick,
  input  wire logic write_op,
  output logic      enable_end
);
  logic [4:0] count;
  wire  [4:0] mask = write_op ? scx_pkg::END_WR_MASK
                              : scx_pkg::END_RD_MASK;
  wire        hit  = (count & mask) == mask;

  always_ff @(posedge clock) begin
    if (sys_rst || !run)
      count <= 5'h00;
    else if (tick && !hit)
      count <= count + 5'h01;
  end

  // Decode is taken on the period after the matching count
  always_ff @(posedge clock) begin
    if (sys_rst || !run)
      enable_end <= 1'b0;
    else if (tick && hit)
      enable_end <= 1'b1;
  end
endmodule

// ==== tb/scx_far_model.sv ====
// Far-side model: memory control word source and bulk-store controller
`timescale 1ns/1ps
module scx_far_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       memory_side_request,
  input  wire logic       bulk_store_request,
  input  wire logic [7:0] gap,
  output logic            word_strobe,
  output logic            ctrl_accept
);
  // ----------------------------------------------------------------
  // Pacing
  // ----------------------------------------------------------------
  // Neither side moves more than one word per 100 ns period; gap slows it
  logic [8:0] word_cnt;
  logic [8:0] acc_cnt;
  wire  [8:0] pace = 9'h18 + {1'b0, gap};

  always @(posedge clock) begin
    if (sys_rst || !memory_side_request) begin
      word_cnt <= 9'h000;
    end else begin
      word_cnt <= (word_cnt >= pace) ? 9'h000 : word_cnt + 9'h001;
    end
    if (sys_rst || !bulk_store_request) begin
      acc_cnt <= 9'h000;
    end else begin
      acc_cnt <= (acc_cnt >= pace) ? 9'h000 : acc_cnt + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  // Pulses stay ten cycles wide so the input synchronisers see them
  always @(posedge clock) begin
    word_strobe <= !sys_rst && memory_side_request && (word_cnt < 9'h00a);
    // Accepts the flag address or each word while the request stands
    ctrl_accept <= !sys_rst && bulk_store_request && (acc_cnt < 9'h00a);
  end
endmodule

// ==== tb/test_store_coupler_transfer_control.sv ====
// Self-checking bench for the store coupler transfer control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("BAD %0t mismatch in %s", $time, tname); end end
module test_store_coupler_transfer_control;
  logic       clock, sys_rst, coupler_accept, write_op, ctrl_accept;
  logic       ctrl_abort, error_flag, wc_zero, cpu_exchange_terminate;
  logic       word_strobe, addr_bit23, master_clear;
  logic       memory_side_request, bulk_store_request, buf_read_half;
  logic [3:0] buf_addr;
  logic       end_of_transfer, store_end_of_transfer, error_end_of_transfer;
  logic       abort_to_code_gen, zero_fill, transfer_clear;
  logic [7:0] gap;
  int         bad_count, checks, cyc, end_cyc, t0, n;
  logic [2:0] exp_q[$];
  string      tname;

  scx_xfer_ctl u_scx_xfer_ctl (.clock, .sys_rst, .coupler_accept, .write_op,
    .ctrl_accept, .ctrl_abort, .error_flag, .wc_zero,
    .cpu_exchange_terminate, .word_strobe, .addr_bit23, .master_clear,
    .memory_side_request, .bulk_store_request, .buf_addr, .buf_read_half,
    .end_of_transfer, .store_end_of_transfer, .error_end_of_transfer,
    .abort_to_code_gen, .zero_fill, .transfer_clear);
  scx_far_model u_scx_far_model (.clock, .sys_rst, .memory_side_request,
    .bulk_store_request, .gap, .word_strobe, .ctrl_accept);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Closing, timeout and end-pulse monitor
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Counts: checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  // Each end pulse takes the oldest expected {end, store end, error end}
  always @(posedge clock) begin
    if ((end_of_transfer | store_end_of_transfer | error_end_of_transfer)
        === 1'b1) begin
      end_cyc = cyc;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("BAD %0t unexpected end in %s", $time, tname);
      end else begin
        `CHK({end_of_transfer, store_end_of_transfer, error_end_of_transfer}, exp_q.pop_front())
      end
    end
  end

  // ----------------------------------------------------------------
  // Driver tasks
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic start(input logic w, input logic f);
    write_op <= w;
    addr_bit23 <= f;
    coupler_accept <= 1'b1;
    tick(10);
    coupler_accept <= 1'b0;
  endtask

  // Bounded wait for transfer clear to rise and fall, then tidy inputs
  task automatic wait_done;
    int k;
    k = 0;
    while (transfer_clear !== 1'b1 && k < 3000) begin tick(1); k++; end
    while (transfer_clear !== 1'b0 && k < 3000) begin tick(1); k++; end
    `CHK(k < 3000, 1'b1)
    wc_zero <= 1'b0;
    ctrl_abort <= 1'b0;
    error_flag <= 1'b0;
    cpu_exchange_terminate <= 1'b0;
    addr_bit23 <= 1'b0;
    tick(10);
    $display("Test %s done", tname);
  endtask

  // Counts memory words seen before the controller request appears
  task automatic req_check(input logic w);
    int k, ws;
    logic prev;
    k = 0;
    ws = 0;
    // A strobe already high on entry rose during the accept
    prev = 1'b0;
    while (bulk_store_request !== 1'b1 && k < 500) begin
      tick(1);
      k++;
      if (word_strobe === 1'b1 && prev === 1'b0) ws++;
      prev = word_strobe;
    end
    `CHK(bulk_store_request, 1'b1)
    `CHK(ws, w ? 2 : 0)
    `CHK(memory_side_request, w)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, coupler_accept, write_op, ctrl_abort, error_flag} = 5'h10;
    {wc_zero, cpu_exchange_terminate, addr_bit23, master_clear} = 4'h0;
    gap = 8'h00;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    tname = "reset";
    void'($urandom(51134));
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
    tname = "halves";
    n = 0;
    // Idle noise on abort and terminate must be refused while not busy
    repeat (250) begin
      ctrl_abort <= 1'($urandom);
      cpu_exchange_terminate <= 1'($urandom);
      tick(1);
      n += int'(buf_read_half === 1'b1);
    end
    `CHK(n, 130)
    ctrl_abort <= 1'b0;
    cpu_exchange_terminate <= 1'b0;
    tick(10);
    `CHK(abort_to_code_gen, 1'b0)
    $display("Test %s done", tname);
    tname = "early_zero";
    wc_zero <= 1'b1;
    exp_q.push_back(3'b110);
    start(1'b0, 1'b0);
    wait_done;
    tname = "early_error";
    error_flag <= 1'b1;
    exp_q.push_back(3'b011);
    start(1'b1, 1'b0);
    wait_done;
    for (int w = 0; w < 2; w++) begin
      tname = w ? "write" : "read";
      gap <= 8'($urandom_range(0, 20));
      exp_q.push_back(3'b110);
      start(w[0], 1'b0);
      req_check(w[0]);
      // Stay clear of the early-end window after accept
      tick($urandom_range(150, 300));
      wc_zero <= 1'b1;
      t0 = cyc;
      wait_done;
      // Counter steps on the shared phase, so the first step may come early
      `CHK(end_cyc - t0 >= 515 + 100 * w, 1'b1)
      `CHK(end_cyc - t0 <= 600 + 120 * w, 1'b1)
    end
    tname = "write_abort";
    start(1'b1, 1'b0);
    tick(100);
    exp_q.push_back(3'b011);
    ctrl_abort <= 1'b1;
    wait_done;
    `CHK(abort_to_code_gen, 1'b1)
    tname = "read_abort";
    start(1'b0, 1'b0);
    tick(20);
    `CHK(abort_to_code_gen, 1'b0)
    tick(80);
    ctrl_abort <= 1'b1;
    tick(700);
    `CHK(zero_fill, 1'b1)
    `CHK(transfer_clear, 1'b0)
    exp_q.push_back(3'b011);
    cpu_exchange_terminate <= 1'b1;
    wait_done;
    tname = "exchange";
    start(1'b0, 1'b0);
    tick(100);
    exp_q.push_back(3'b010);
    cpu_exchange_terminate <= 1'b1;
    wait_done;
    tname = "flag_op";
    exp_q.push_back(3'b110);
    start(1'b0, 1'b1);
    wait_done;
    `CHK(buf_addr, 4'h0)
    tname = "master_clear";
    start(1'b1, 1'b0);
    tick(100);
    master_clear <= 1'b1;
    tick(10);
    // Master clear clears directly; the clear output itself stays low
    `CHK(transfer_clear, 1'b0)
    `CHK(memory_side_request, 1'b0)
    master_clear <= 1'b0;
    tick(20);
    $display("Test %s done", tname);
    `CHK(bulk_store_request, 1'b0)
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
